// ===== scss_top.sv
// Serial channel clock-source selection, bit timing and transmit-end interrupt gating
// Notes on behaviour
// [R1] Card mode: three-bit select gives 93,128,186,512,32,64,372,256 base cycles per bit.
// [R2] Select high bit from card mode register, low two bits from serial mode register.
// [R3] Transmit-end interrupt forwarded only while its enable bit is one.
// [R4] Simple I2C: bus condition completion raises transmit-end line, same enable.
// [R5] Async, select 00: internal baud generator, clock pin left free.
// [R6] Async, select 01: internal generator, pin driven at bit-rate frequency.
// [R7] Async external clock: partner supplies sixteen times the bit rate.
// [R8] Half oversample set with external clock: partner supplies eight times bit rate.
// [R9] Async, select 1X: timer clock on supporting channels, pin stays free.
// [R10] Sync, select 0X: clock generated internally and driven on the pin.
// [R11] Sync, select 1X: pin is input, partner drives clock, shifting follows it.
// [R12] Communication mode bit: zero asynchronous, one clock synchronous.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module scss_top
  import scss_pkg::*;
#(
  parameter bit TIMER_CLOCK_PRESENT = 1'b1
) (
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_we_i,
  input  wire logic              reg_re_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  input  wire logic              serial_clock_pin_i,
  output logic                   serial_clock_pin_o,
  output logic                   serial_clock_pin_oe_n_o,
  output logic                   pin_free_o,
  input  wire logic              internal_timer_clock_i,
  input  wire logic              tx_end_i,
  input  wire logic              bus_condition_done_i,
  output logic                   sample_tick_o,
  output logic                   bit_tick_o,
  output logic      [CYC_W-1:0]  base_cycles_o,
  output logic                   parity_odd_even_select_o,
  output logic                   sync_mode_o,
  output logic                   tx_end_irq_o,
  output logic                   irq_o
);

  // ==========================================================================
  // Register file
  scss_mode_t        serial_mode_reg;
  scss_ctrl_t        serial_control_reg;
  scss_card_t        card_mode_reg;
  scss_ext_t         extended_mode_reg;
  logic [DATA_W-1:0] baud_divisor;
  logic [IRQ_W-1:0]  irq_status;
  logic [IRQ_W-1:0]  irq_enable;
  logic [IRQ_W-1:0]  irq_events;
  logic [IRQ_W-1:0]  irq_clear;
  logic [IRQ_W-1:0]  next_irq_status;
  scss_src_t         src;
  scss_src_t         next_src;
  logic              baud_tick;
  logic              pin_rise;
  logic              samp;
  logic              next_bit;
  logic [CYC_W-1:0]  cnt;
  logic [CYC_W-1:0]  limit;
  logic              src_changed;
  logic              drive_pin;
  logic              toggle_pin;

  // Reserved bits are masked on write so they always read back as zero
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      serial_mode_reg    <= scss_mode_t'(RST_REG);
      serial_control_reg <= scss_ctrl_t'(RST_REG);
      card_mode_reg      <= scss_card_t'(RST_REG);
      extended_mode_reg  <= scss_ext_t'(RST_REG);
      baud_divisor       <= RST_BAUD;
      irq_enable         <= RST_REG[IRQ_W-1:0];
    end else if (reg_we_i) begin
      case (reg_addr_i)
        OFS_MODE:   serial_mode_reg    <= scss_mode_t'(reg_wdata_i & MASK_MODE);
        OFS_CTRL:   serial_control_reg <= scss_ctrl_t'(reg_wdata_i & MASK_CTRL);
        OFS_CARD:   card_mode_reg      <= scss_card_t'(reg_wdata_i & MASK_CARD);
        OFS_EXT:    extended_mode_reg  <= scss_ext_t'(reg_wdata_i & MASK_EXT);
        OFS_BAUD:   baud_divisor       <= reg_wdata_i;
        OFS_IRQ_EN: irq_enable         <= reg_wdata_i[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Read data stands for one cycle per cycle of the read strobe; unmapped and write-only offsets read zero
  always_ff @(posedge clock_i) begin
    if (rst_i || !reg_re_i) begin
      reg_rdata_o <= '0;
    end else begin
      case (reg_addr_i)
        OFS_MODE:     reg_rdata_o <= serial_mode_reg;
        OFS_CTRL:     reg_rdata_o <= serial_control_reg;
        OFS_CARD:     reg_rdata_o <= card_mode_reg;
        OFS_EXT:      reg_rdata_o <= extended_mode_reg;
        OFS_BAUD:     reg_rdata_o <= baud_divisor;
        OFS_IRQ_STAT: reg_rdata_o <= {{(DATA_W-IRQ_W){1'b0}}, irq_status};
        OFS_IRQ_EN:   reg_rdata_o <= {{(DATA_W-IRQ_W){1'b0}}, irq_enable};
        OFS_CLK_STAT: reg_rdata_o <= {~serial_clock_pin_oe_n_o, 7'(src)};
        default:      reg_rdata_o <= '0;
      endcase
    end
  end

  // ==========================================================================
  // Sticky interrupt status; a new event beats a clear in the same cycle
  assign irq_events[IRQ_TX_END]   = tx_end_i;
  assign irq_events[IRQ_BUS_COND] = bus_condition_done_i;
  assign irq_clear = (reg_we_i && reg_addr_i == OFS_IRQ_CLR) ? reg_wdata_i[IRQ_W-1:0] : '0;
  assign next_irq_status = (irq_status & ~irq_clear) | irq_events;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  assign irq_o = |(irq_status & irq_enable);

  // In simple I2C mode the bus-condition event takes the transmit-end line
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tx_end_irq_o <= 1'b0;
    end else begin
      tx_end_irq_o <= serial_control_reg.tx_end_irq_enable &                     // R3
                      (card_mode_reg.simple_i2c_mode ? bus_condition_done_i      // R4
                                                     : tx_end_i);
    end
  end

  // ==========================================================================
  // Clock-source selection
  always_comb begin
    next_src = SRC_ASYNC_INT;
    if (card_mode_reg.card_interface_mode_sel) begin
      next_src = SRC_CARD;
    end else if (serial_mode_reg.comm_mode_sel) begin                               // R12
      next_src = serial_control_reg.clock_enable_sel[1] ? SRC_SYNC_EXT : SRC_SYNC_INT; // R10
    end else if (serial_control_reg.clock_enable_sel == CKSEL_INT_NOPIN) begin
      next_src = SRC_ASYNC_INT;                                                     // R5
    end else if (serial_control_reg.clock_enable_sel == CKSEL_INT_PIN) begin
      next_src = SRC_ASYNC_INT_OUT;                                                 // R6
    end else if (TIMER_CLOCK_PRESENT && extended_mode_reg.timer_clock_sel) begin
      next_src = SRC_ASYNC_TMR;                                                     // R9
    end else begin
      next_src = SRC_ASYNC_EXT;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      src <= SRC_ASYNC_INT;
    end else begin
      src <= next_src;
    end
  end

  // A source change restarts the baud generator and the sample counter, so the
  // first bit after a switch has its full length
  assign src_changed = (src != next_src);

  scss_baud_gen u_baud (
    .clock_i   (clock_i),
    .rst_i     (rst_i),
    .restart_i (src_changed),
    .divisor_i (baud_divisor),
    .tick_o    (baud_tick)
  );

  scss_pin_sync u_pin (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin_i   (serial_clock_pin_i),
    .level_o (),
    .rise_o  (pin_rise)
  );

  // ==========================================================================
  // Sample ticks and samples-per-bit limit
  always_comb begin
    case (src)
      SRC_ASYNC_EXT: samp = pin_rise;
      SRC_SYNC_EXT:  samp = pin_rise;
      SRC_ASYNC_TMR: samp = internal_timer_clock_i;
      default:       samp = baud_tick;
    endcase
  end

  // External clock ticks are sampled by this clock, so the partner clock must stay
  // well below half the module clock rate
  always_comb begin
    if (src == SRC_CARD) begin
      limit = scss_base_cycles({card_mode_reg.base_cycles_high_sel,                 // R2
                                serial_mode_reg.base_cycles_low_sel});              // R1
    end else if (extended_mode_reg.half_oversample_sel) begin
      limit = OVS_HALF;                                                             // R8
    end else begin
      limit = OVS_FULL;                                                             // R7
    end
  end

  // A limit lowered mid-bit below the count ends that bit early rather than late
  always_ff @(posedge clock_i) begin
    if (rst_i || src_changed) begin
      cnt <= '0;
    end else if (samp) begin
      cnt <= (cnt >= limit - 1'b1) ? '0 : cnt + 1'b1;
    end
  end

  // Internal sync clock: one bit per pin period, on the rising pin edge
  always_comb begin
    case (src)
      SRC_SYNC_INT: next_bit = baud_tick & ~serial_clock_pin_o;                    // R10
      SRC_SYNC_EXT: next_bit = pin_rise;                                            // R11
      default:      next_bit = samp && (cnt >= limit - 1'b1);
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i || src_changed) begin
      bit_tick_o    <= 1'b0;
      sample_tick_o <= 1'b0;
    end else begin
      bit_tick_o    <= next_bit;
      sample_tick_o <= samp;
    end
  end

  // ==========================================================================
  // Serial clock pin
  // Card mode drives the pin only while the low clock-enable bit is set
  assign drive_pin = (src == SRC_ASYNC_INT_OUT) || (src == SRC_SYNC_INT) ||         // R6 R10
                     ((src == SRC_CARD) && serial_control_reg.clock_enable_sel[0]);
  // Two toggles per bit give one pin period per bit in asynchronous output mode
  assign toggle_pin = (src == SRC_SYNC_INT) ? baud_tick
                    : samp && (cnt == '0 || cnt == (limit >> 1));

  always_ff @(posedge clock_i) begin
    if (rst_i || !drive_pin) begin
      serial_clock_pin_o <= 1'b1;
    end else if (toggle_pin) begin
      serial_clock_pin_o <= ~serial_clock_pin_o;
    end
  end

  // Output enable stays off in the cycle of a source change, so the pin never
  // sees two drivers while ownership moves
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      serial_clock_pin_oe_n_o  <= 1'b1;
      pin_free_o               <= 1'b1;
      base_cycles_o            <= BASE_S0;
      parity_odd_even_select_o <= 1'b0;
      sync_mode_o              <= 1'b0;
    end else begin
      serial_clock_pin_oe_n_o  <= ~(drive_pin && !src_changed);                     // R11
      pin_free_o               <= (next_src == SRC_ASYNC_INT) || (next_src == SRC_ASYNC_TMR) || // R5 R9
                                  ((next_src == SRC_CARD) && !serial_control_reg.clock_enable_sel[0]);
      base_cycles_o            <= limit;                                            // R1
      parity_odd_even_select_o <= serial_mode_reg.parity_odd_even_select;
      sync_mode_o              <= serial_mode_reg.comm_mode_sel;                    // R12
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_card_cycle_map: assert property ((src == SRC_CARD) && !src_changed &&    // R1
    card_mode_reg.base_cycles_high_sel && serial_mode_reg.base_cycles_low_sel == 2'h2
    |=> base_cycles_o == 10'h174) else $error("card mode select 110 not 372 cycles");
  a_card_sel_split: assert property ((src == SRC_CARD) && $stable(card_mode_reg) && // R2
    $stable(serial_mode_reg) |=> base_cycles_o == scss_base_cycles(
    {$past(card_mode_reg.base_cycles_high_sel), $past(serial_mode_reg.base_cycles_low_sel)}))
    else $error("base cycles not built from both registers");
  a_tei_suppress: assert property (!serial_control_reg.tx_end_irq_enable |=> !tx_end_irq_o) // R3
    else $error("transmit-end line raised while disabled");
  a_tei_forward: assert property (serial_control_reg.tx_end_irq_enable &&    // R3
    !card_mode_reg.simple_i2c_mode && tx_end_i |=> tx_end_irq_o)
    else $error("enabled transmit-end event not forwarded");
  a_i2c_cond_irq: assert property (serial_control_reg.tx_end_irq_enable &&   // R4
    card_mode_reg.simple_i2c_mode && bus_condition_done_i |=> tx_end_irq_o)
    else $error("bus condition completion not forwarded");
  a_async_pin_free: assert property ((src == SRC_ASYNC_INT) && $stable(src) |-> // R5
    serial_clock_pin_oe_n_o && pin_free_o) else $error("pin not free in async select 00");
  a_async_clk_out: assert property ((src == SRC_ASYNC_INT_OUT) && samp && cnt == '0 && // R6
    !src_changed |=> serial_clock_pin_o != $past(serial_clock_pin_o))
    else $error("async pin clock did not toggle at bit start");
  a_ext_oversample: assert property ((src == SRC_ASYNC_EXT) &&               // R7
    !extended_mode_reg.half_oversample_sel |-> limit == 10'h010)
    else $error("external clock not divided by sixteen");
  a_half_oversample: assert property ((src == SRC_ASYNC_EXT) &&              // R8
    extended_mode_reg.half_oversample_sel |-> limit == 10'h008)
    else $error("half oversample not divided by eight");
  a_timer_pin_free: assert property ((src == SRC_ASYNC_TMR) && $stable(src) && !src_changed |=> pin_free_o) // R9
    else $error("pin claimed while timer clock in use");
  a_sync_int_drive: assert property ((src == SRC_SYNC_INT) && $stable(src) && !src_changed |=> // R10
    !serial_clock_pin_oe_n_o) else $error("internal sync clock not driven");
  a_sync_ext_shift: assert property ((src == SRC_SYNC_EXT) && pin_rise && !src_changed // R11
    |=> bit_tick_o && serial_clock_pin_oe_n_o) else $error("external sync edge not followed");
  a_mode_select: assert property (serial_mode_reg.comm_mode_sel &&           // R12
    !card_mode_reg.card_interface_mode_sel |=> src inside {SRC_SYNC_INT, SRC_SYNC_EXT})
    else $error("comm mode one did not select sync operation");

  // ==========================================================================
  // Pin ownership, per-mode timing and simple I2C transmit-end masking
  a_card_base_93: assert property ((src == SRC_CARD) && !src_changed &&      // R1
    !card_mode_reg.base_cycles_high_sel && serial_mode_reg.base_cycles_low_sel == 2'h0
    |=> base_cycles_o == 10'h05D) else $error("card select 000 not 93 cycles");
  a_card_high_bit: assert property ((src == SRC_CARD) && !src_changed &&     // R2
    card_mode_reg.base_cycles_high_sel && serial_mode_reg.base_cycles_low_sel == 2'h0
    |=> base_cycles_o == 10'h020) else $error("card high select bit ignored");
  a_tei_i2c_mask: assert property (card_mode_reg.simple_i2c_mode &&          // R4
    !bus_condition_done_i |=> !tx_end_irq_o) else $error("transmit-end line raised in i2c mode");
  a_async_pin_idle: assert property ((src == SRC_ASYNC_INT) |=>              // R5
    serial_clock_pin_o && serial_clock_pin_oe_n_o) else $error("pin not idle in async select 00");
  a_timer_sample: assert property ((src == SRC_ASYNC_TMR) &&                 // R9
    internal_timer_clock_i && !src_changed |=> sample_tick_o)
    else $error("timer pulse not taken as sample tick");
  a_sync_int_toggle: assert property ((src == SRC_SYNC_INT) && baud_tick &&  // R10
    !src_changed |=> serial_clock_pin_o != $past(serial_clock_pin_o))
    else $error("internal sync clock did not toggle");
  a_sync_ext_input: assert property ((src == SRC_SYNC_EXT) |=>               // R11
    serial_clock_pin_oe_n_o) else $error("pin driven with external sync clock");

  c_card_bit: cover property ((src == SRC_CARD) && bit_tick_o);
  c_async_out_bit: cover property ((src == SRC_ASYNC_INT_OUT) && bit_tick_o);
  c_sync_ext_bit: cover property ((src == SRC_SYNC_EXT) && bit_tick_o);
  c_i2c_irq: cover property (card_mode_reg.simple_i2c_mode && tx_end_irq_o);
  c_timer_bit: cover property ((src == SRC_ASYNC_TMR) && bit_tick_o);

endmodule : scss_top
`default_nettype wire

// ===== scss_pkg.sv
// Package: register map, field layouts, clock-source states and bit-timing constants
package scss_pkg;

  // ==========================================================================
  // Register port geometry and offsets
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] OFS_MODE     = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_CARD     = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_EXT      = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_BAUD     = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_CLK_STAT = 4'h8;

  // ==========================================================================
  // Reset values and writable-bit masks
  localparam logic [DATA_W-1:0] RST_REG   = 8'h00;
  localparam logic [DATA_W-1:0] RST_BAUD  = 8'h03;
  localparam logic [DATA_W-1:0] MASK_MODE = 8'h9C;
  localparam logic [DATA_W-1:0] MASK_CTRL = 8'h07;
  localparam logic [DATA_W-1:0] MASK_CARD = 8'h13;
  localparam logic [DATA_W-1:0] MASK_EXT  = 8'h03;

  // ==========================================================================
  // Field layouts
  typedef struct packed {
    logic       comm_mode_sel;
    logic [1:0] rsvd_hi;
    logic       parity_odd_even_select;
    logic [1:0] base_cycles_low_sel;
    logic [1:0] rsvd_lo;
  } scss_mode_t;

  typedef struct packed {
    logic [4:0] rsvd;
    logic       tx_end_irq_enable;
    logic [1:0] clock_enable_sel;
  } scss_ctrl_t;

  typedef struct packed {
    logic [2:0] rsvd_hi;
    logic       base_cycles_high_sel;
    logic [1:0] rsvd_lo;
    logic       simple_i2c_mode;
    logic       card_interface_mode_sel;
  } scss_card_t;

  typedef struct packed {
    logic [5:0] rsvd;
    logic       timer_clock_sel;
    logic       half_oversample_sel;
  } scss_ext_t;

  localparam int unsigned IRQ_W        = 2;
  localparam int unsigned IRQ_TX_END   = 0;
  localparam int unsigned IRQ_BUS_COND = 1;

  localparam logic [1:0] CKSEL_INT_NOPIN = 2'h0;
  localparam logic [1:0] CKSEL_INT_PIN   = 2'h1;

  // ==========================================================================
  // Clock-source states, one-hot
  typedef enum logic [6:0] {
    SRC_ASYNC_INT     = 7'h01,
    SRC_ASYNC_INT_OUT = 7'h02,
    SRC_ASYNC_EXT     = 7'h04,
    SRC_ASYNC_TMR     = 7'h08,
    SRC_SYNC_INT      = 7'h10,
    SRC_SYNC_EXT      = 7'h20,
    SRC_CARD          = 7'h40
  } scss_src_t;

  // ==========================================================================
  // Bit timing
  localparam int unsigned CYC_W = 10;
  localparam logic [CYC_W-1:0] OVS_FULL = 10'h010;
  localparam logic [CYC_W-1:0] OVS_HALF = 10'h008;
  localparam logic [CYC_W-1:0] BASE_S0  = 10'h05D;
  localparam logic [CYC_W-1:0] BASE_S1  = 10'h080;
  localparam logic [CYC_W-1:0] BASE_S2  = 10'h0BA;
  localparam logic [CYC_W-1:0] BASE_S3  = 10'h200;
  localparam logic [CYC_W-1:0] BASE_S4  = 10'h020;
  localparam logic [CYC_W-1:0] BASE_S5  = 10'h040;
  localparam logic [CYC_W-1:0] BASE_S6  = 10'h174;
  localparam logic [CYC_W-1:0] BASE_S7  = 10'h100;

  function automatic logic [CYC_W-1:0] scss_base_cycles(input logic [2:0] sel);
    case (sel)
      3'h0:    scss_base_cycles = BASE_S0;
      3'h1:    scss_base_cycles = BASE_S1;
      3'h2:    scss_base_cycles = BASE_S2;
      3'h3:    scss_base_cycles = BASE_S3;
      3'h4:    scss_base_cycles = BASE_S4;
      3'h5:    scss_base_cycles = BASE_S5;
      3'h6:    scss_base_cycles = BASE_S6;
      default: scss_base_cycles = BASE_S7;
    endcase
  endfunction : scss_base_cycles

endpackage : scss_pkg

// ===== scss_pin_sync.sv
// Two-flop synchroniser with edge detection for the serial clock pin
`timescale 1ns/1ps
`default_nettype none
module scss_pin_sync (
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o
);
  logic meta;
  logic sync;
  logic last;

  // ==========================================================================
  // Only the second stage and later are looked at
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta <= 1'b1;
      sync <= 1'b1;
      last <= 1'b1;
    end else begin
      meta <= pin_i;
      sync <= meta;
      last <= sync;
    end
  end

  assign level_o = sync;
  assign rise_o  = sync & ~last;
endmodule : scss_pin_sync
`default_nettype wire

// ===== scss_baud_gen.sv
// Internal baud generator: one-cycle tick every divisor+1 clock cycles
`timescale 1ns/1ps
`default_nettype none
module scss_baud_gen
  import scss_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic              restart_i,
  input  wire logic [DATA_W-1:0] divisor_i,
  output logic                   tick_o
);
  logic [DATA_W-1:0] count;

  // ==========================================================================
  // Down-counter; a restart realigns the phase after a source change
  always_ff @(posedge clock_i) begin
    if (rst_i || restart_i) begin
      count  <= RST_BAUD;
      tick_o <= 1'b0;
    end else if (count == '0) begin
      count  <= divisor_i;
      tick_o <= 1'b1;
    end else begin
      count  <= count - 1'b1;
      tick_o <= 1'b0;
    end
  end
endmodule : scss_baud_gen
`default_nettype wire

// ===== scss_far_end.sv
// Far-end serial clock source sharing the clock pin with the device
`timescale 1ns/1ps
`default_nettype none
module scss_far_end (
  input  wire logic en_i,
  input  wire logic dev_pin_i,
  input  wire logic dev_oe_n_i,
  output logic      pin_o
);
  logic clk_drv = 1'b1;
  // ==========================================================================
  // Clock of 160 ns period inside frames, standing high between them
  always begin
    if (en_i) begin
      clk_drv = 1'b0;
      #80;
      clk_drv = 1'b1;
      #80;
    end else begin
      @(posedge en_i);
    end
  end
  // Device drive wins; a released pin carries the far-end clock, high between frames
  assign pin_o = !dev_oe_n_i ? dev_pin_i : clk_drv;
endmodule : scss_far_end
`default_nettype wire

// ===== scss_top_bench.sv
// Self-checking bench for serial clock source selection
`timescale 1ns/1ps
`default_nettype none
module scss_top_bench;
  import scss_pkg::*;
  logic              clock_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              we = 1'b0;
  logic              re = 1'b0;
  logic              re_d = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic              tmr = 1'b0;
  logic              txe = 1'b0;
  logic              bcd = 1'b0;
  logic              far_en = 1'b0;
  logic              pin_w, pin_o, pin_d, oe_n, free, b_tick, teirq, irq, sync, s_tick, par;
  logic [CYC_W-1:0]  base;
  logic [DATA_W-1:0] exp_q[$];
  logic [1:0]        cke[6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h0, 2'h2};
  logic [7:0]        stat[6] = '{8'h01, 8'h82, 8'h04, 8'h08, 8'h90, 8'h20};
  logic [7:0]        msk[4] = '{MASK_MODE, MASK_CTRL, MASK_CARD, MASK_EXT};
  logic [9:0]        tbl[8] = '{10'h05D, 10'h080, 10'h0BA, 10'h200, 10'h020, 10'h040, 10'h174, 10'h100};
  int                bad_count = 0, n_checks = 0, bits = 0, rises = 0, pulses = 0, samps = 0;
  int                seed = 32'h6AC2;

  initial forever #2.5 clock_i = ~clock_i;

  scss_top dut (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .serial_clock_pin_i(pin_w),
    .serial_clock_pin_o(pin_o), .serial_clock_pin_oe_n_o(oe_n), .pin_free_o(free),
    .internal_timer_clock_i(tmr), .tx_end_i(txe), .bus_condition_done_i(bcd), .sample_tick_o(s_tick),
    .bit_tick_o(b_tick), .base_cycles_o(base), .parity_odd_even_select_o(par), .sync_mode_o(sync),
    .tx_end_irq_o(teirq), .irq_o(irq));
  scss_far_end far (.en_i(far_en), .dev_pin_i(pin_o), .dev_oe_n_i(oe_n), .pin_o(pin_w));

  // ==========================================================================
  // Checking and bus tasks
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (e !== s) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", w, e, s);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cyc

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock_i);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock_i);
    we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    exp_q.push_back(e);
    @(posedge clock_i);
    re <= 1'b1;
    addr <= a;
    @(posedge clock_i);
    re <= 1'b0;
  endtask : rd

  task automatic pulse(input bit bus_cond);
    @(posedge clock_i);
    if (bus_cond) bcd <= 1'b1;
    else txe <= 1'b1;
    @(posedge clock_i);
    bcd <= 1'b0;
    txe <= 1'b0;
  endtask : pulse

  // Far clock frames are cut short of a period boundary so no extra period starts
  task automatic run_far(input int n, input int e);
    int b0, s0;
    b0 = bits;
    s0 = samps;
    @(posedge clock_i);
    far_en <= 1'b1;
    cyc(n * 32 - 8);
    far_en <= 1'b0;
    cyc(12);
    chk("bit_ticks", e, bits - b0);
    chk("sample_ticks", n, samps - s0);
  endtask : run_far

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Output watcher: read data against oldest note, event counters
  always @(posedge clock_i) begin
    re_d <= re;
    pin_d <= pin_o;
    tmr <= ~tmr;
    bits <= bits + int'(b_tick);
    samps <= samps + int'(s_tick);
    pulses <= pulses + int'(teirq);
    rises <= rises + int'(pin_o & ~pin_d);
    if (re_d) chk("rdata", exp_q.pop_front(), rdata);
  end

  initial begin
    cyc(100000);
    bad_count++;
    stop_test();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [7:0] r;
    int b0, r0, p0;
    cyc(5);
    rst_i <= 1'b0;
    cyc(1);
    chk("pin_free", 1, free);
    chk("base_cycles", 10'h05D, base);
    for (int a = 0; a < 16; a++) rd(a[3:0], a == 4 ? 8'h03 : a == 8 ? 8'h01 : 8'h00);
    for (int i = 0; i < 4; i++) begin
      r = 8'($random(seed));
      wr(i[3:0], r);
      rd(i[3:0], r & msk[i]);
      if (i == 0) chk("parity", r[4], par);
      wr(i[3:0], 8'h00);
    end
    for (int s = 0; s < 8; s++) begin
      wr(OFS_CARD, {3'h0, s[2], 4'h1});
      wr(OFS_MODE, {4'h0, s[1:0], 2'h0});
      cyc(4);
      chk("base_cycles", tbl[s], base);
    end
    wr(OFS_CARD, 8'h00);
    for (int m = 0; m < 6; m++) begin
      wr(OFS_EXT, m == 3 ? 8'h02 : 8'h00);
      wr(OFS_CTRL, {6'h0, cke[m]});
      wr(OFS_MODE, {m > 3, 7'h0});
      cyc(4);
      chk("pin_free", stat[m] inside {8'h01, 8'h08}, free);
      chk("oe_n", !stat[m][7], oe_n);
      chk("sync", m > 3, sync);
      rd(OFS_CLK_STAT, stat[m]);
      b0 = bits;
      r0 = rises;
      cyc(640);
      if (stat[m][7]) chk("clock_per_bit", 1, (bits - b0 - rises + r0) inside {-1, 0, 1} && bits > b0 + 4);
    end
    wr(OFS_CTRL, 8'h02);
    wr(OFS_MODE, 8'h00);
    for (int h = 0; h < 2; h++) begin
      wr(OFS_EXT, {7'h0, h[0]});
      cyc(4);
      chk("base_cycles", h ? 10'h008 : 10'h010, base);
      run_far(h ? 16 : 32, 2);
    end
    wr(OFS_EXT, 8'h00);
    wr(OFS_MODE, 8'h80);
    run_far(5, 5);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_IRQ_EN, 8'h03);
    p0 = pulses;
    pulse(0);
    cyc(3);
    chk("tx_end_irq", 0, pulses - p0);
    chk("irq", 1, irq);
    wr(OFS_CTRL, 8'h04);
    pulse(0);
    cyc(3);
    chk("tx_end_irq", 1, pulses - p0);
    wr(OFS_CARD, 8'h02);
    pulse(0);
    pulse(1);
    cyc(3);
    chk("tx_end_irq", 2, pulses - p0);
    rd(OFS_IRQ_STAT, 8'h03);
    wr(OFS_CTRL, 8'h00);
    pulse(1);
    cyc(3);
    chk("tx_end_irq", 2, pulses - p0);
    wr(OFS_IRQ_EN, 8'h00);
    cyc(2);
    chk("irq", 0, irq);
    wr(OFS_IRQ_EN, 8'h02);
    wr(OFS_IRQ_CLR, 8'h02);
    cyc(2);
    chk("irq", 0, irq);
    rd(OFS_IRQ_STAT, 8'h01);
    cyc(4);
    stop_test();
  end
endmodule : scss_top_bench
`default_nettype wire
